// ==== hdl/spcm_regs.vh ====
// Register map, field positions, reset values and bit timing of the serial port
`ifndef SPCM_REGS_VH
`define SPCM_REGS_VH
// ======================================================
// Byte addresses
`define SPCM_ADDR_CTRL 8'h98
`define SPCM_ADDR_DATA 8'h9c
`define SPCM_ADDR_STAT 8'ha0
`define SPCM_ADDR_CFG 8'ha4
`define SPCM_ADDR_IRQ_STAT 8'ha8
`define SPCM_ADDR_IRQ_MASK 8'hac
// ======================================================
// Control register fields
`define SPCM_CTRL_RX_DONE 0
`define SPCM_CTRL_TX_DONE 1
`define SPCM_CTRL_RX_NINTH 2
`define SPCM_CTRL_TX_NINTH 3
`define SPCM_CTRL_RX_EN 4
`define SPCM_CTRL_ADDR_FILT 5
`define SPCM_CTRL_MODE_LO 6
`define SPCM_CTRL_MODE_HI 7
// ======================================================
// Status and configuration fields
`define SPCM_STAT_FRAME_ERR 3
`define SPCM_STAT_EARLY_TX 6
`define SPCM_CFG_ERR_VIEW 0
`define SPCM_CFG_DBL_RATE 1
`define SPCM_CFG_DIV_LSB 8
`define SPCM_IRQ_RX 0
`define SPCM_IRQ_TX 1
`define SPCM_IRQ_FE 2
// ======================================================
// Reset values
`define SPCM_CTRL_RST 8'h00
`define SPCM_DIV_RST 16'h000f
`define SPCM_IRQ_RST 3'h0
// ======================================================
// Modes and bit timing, sixteen ticks per bit
`define SPCM_MODE_SHIFT 2'h0
`define SPCM_MODE_8BIT 2'h1
`define SPCM_MODE_9FIX 2'h2
`define SPCM_MODE_9VAR 2'h3
`define SPCM_TICK_LAST 4'hf
`define SPCM_TICK_MID 4'h7
`define SPCM_TICK_M0_SMP 4'hc
`define SPCM_DIV_CORE16 16'h0000
`define SPCM_DIV_CORE32 16'h0001
`define SPCM_BITS_M0 4'h8
`define SPCM_BITS_M1 4'ha
`define SPCM_BITS_M23 4'hb
`define SPCM_IDX_NINTH 4'h9
`define SPCM_IDX_STOP9 4'ha
`endif

// ==== hdl/spcm_tick_gen.v ====
// Oversampling tick generator, one pulse every divisor+1 clocks
`default_nettype none
module spcm_tick_gen #(
  parameter DIV_W = 16
) (
  input wire clock,
  input wire reset_n,
  input wire [DIV_W-1:0] divisor,
  output reg tick_q
);
  reg [DIV_W-1:0] cnt_q;

  // ======================================================
  // Counter
  // A divisor change takes effect at once; a count at or above the new divisor wraps on the next clock
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= {DIV_W{1'b0}};
      tick_q <= 1'b0;
    end
    else if (cnt_q >= divisor)
    begin
      cnt_q <= {DIV_W{1'b0}};
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/spcm_core.v ====
// Four-mode serial port with Avalon-MM register slave
`include "spcm_regs.vh"
`default_nettype none
module spcm_core #(
  parameter DIV_W = 16
) (
  input wire clock,
  input wire reset_n,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output reg [31:0] readdata_q,
  output reg waitrequest_q,
  output reg irq_q,
  input wire rxd_in,
  output reg rxd_out_q,
  output reg rxd_oe_q,
  output reg txd_q
);
  // ======================================================
  // Declarations
  reg ri_q, ti_q, rb8_q, tb8_q, ren_q, sm2_q, sm1_q, sm0_q, fe_q;
  reg early_tx_flag_select_q, evs_q, dbl_q;
  reg [DIV_W-1:0] div_q;
  reg [7:0] rx_buf_q;
  reg [2:0] irq_st_q, irq_mask_q;
  reg tx_busy_q, m0rx_q, m0_smp_q;
  reg [10:0] tx_sh_q;
  reg [3:0] tx_bits_q, tx_tick_q;
  reg rx_busy_q, rx_prev_q, nine_q;
  reg [3:0] rx_tick_q, rx_idx_q;
  reg [7:0] rx_sh_q;
  reg [31:0] rd_d;
  reg [DIV_W-1:0] div_eff;
  wire tick;
  wire [1:0] mode = {sm0_q, sm1_q};
  wire mode0 = (mode == `SPCM_MODE_SHIFT);
  wire mode1 = (mode == `SPCM_MODE_8BIT);
  wire wr_go = write && !waitrequest_q;
  wire ctrl_wr = wr_go && byteenable[0] && (address == `SPCM_ADDR_CTRL);
  wire data_wr = wr_go && byteenable[0] && (address == `SPCM_ADDR_DATA);
  wire stat_wr = wr_go && byteenable[0] && (address == `SPCM_ADDR_STAT);
  wire cfg_wr = wr_go && (address == `SPCM_ADDR_CFG);
  wire ist_wr = wr_go && byteenable[0] && (address == `SPCM_ADDR_IRQ_STAT);
  wire imk_wr = wr_go && byteenable[0] && (address == `SPCM_ADDR_IRQ_MASK);
  wire [7:0] ctrl_rd = {evs_q ? fe_q : sm0_q, sm1_q, sm2_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};

  // ======================================================
  // Bit-rate selection
  // Modes 1 and 3 take their rate from the divisor register
  always @*
  begin
    case (mode)
      `SPCM_MODE_SHIFT: div_eff = `SPCM_DIV_CORE16;
      `SPCM_MODE_9FIX: div_eff = dbl_q ? `SPCM_DIV_CORE16 : `SPCM_DIV_CORE32;
      default: div_eff = div_q;
    endcase
  end

  spcm_tick_gen #(
    .DIV_W(DIV_W)
  ) u_tick (
    .clock(clock),
    .reset_n(reset_n),
    .divisor(div_eff),
    .tick_q(tick)
  );

  // ======================================================
  // Engine events
  wire tx_bit_end = tx_busy_q && tick && (tx_tick_q == `SPCM_TICK_LAST);
  wire tx_last = (tx_bits_q == 4'h1);
  wire ti_ev = tx_bit_end && !m0rx_q && (mode0 ? tx_last :
    (early_tx_flag_select_q ? (tx_bits_q == 4'h2) : tx_last));
  wire m0_ri_ev = tx_bit_end && m0rx_q && tx_last;
  wire [7:0] m0_data = {m0_smp_q, tx_sh_q[7:1]};
  wire rx_mid = rx_busy_q && tick && (rx_tick_q == `SPCM_TICK_MID);
  wire rx_stop = rx_mid && (mode1 ? (rx_idx_q == `SPCM_IDX_NINTH) : (rx_idx_q == `SPCM_IDX_STOP9));
  wire rx_ninth = rx_mid && !mode1 && (rx_idx_q == `SPCM_IDX_NINTH);
  wire fe_ev = rx_stop && !rxd_in;
  wire rx_deliver = mode1 ? rx_stop : (evs_q ? rx_stop : rx_ninth);
  wire nine_val = (mode1 || rx_ninth) ? rxd_in : nine_q;
  wire rx_accept = rx_deliver && !(sm2_q && !mode1 && !nine_val);
  wire ri_ev = rx_accept || m0_ri_ev;
  wire tx_start = data_wr && !tx_busy_q;
  wire m0rx_start = mode0 && ren_q && !ri_q && !tx_busy_q && !data_wr;

  // ======================================================
  // Avalon slave
  // One wait state on every access keeps read data registered
  always @*
  begin
    rd_d = 32'h0000_0000;
    case (address)
      `SPCM_ADDR_CTRL: rd_d[7:0] = ctrl_rd;
      `SPCM_ADDR_DATA: rd_d[7:0] = rx_buf_q;
      `SPCM_ADDR_STAT:
      begin
        rd_d[`SPCM_STAT_EARLY_TX] = early_tx_flag_select_q;
        rd_d[`SPCM_STAT_FRAME_ERR] = fe_q;
      end
      `SPCM_ADDR_CFG:
      begin
        rd_d[`SPCM_CFG_ERR_VIEW] = evs_q;
        rd_d[`SPCM_CFG_DBL_RATE] = dbl_q;
        rd_d[`SPCM_CFG_DIV_LSB+DIV_W-1:`SPCM_CFG_DIV_LSB] = div_q;
      end
      `SPCM_ADDR_IRQ_STAT: rd_d[2:0] = irq_st_q;
      `SPCM_ADDR_IRQ_MASK: rd_d[2:0] = irq_mask_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end
    else if ((read || write) && waitrequest_q)
    begin
      waitrequest_q <= 1'b0;
      readdata_q <= rd_d;
    end
    else
    begin
      waitrequest_q <= 1'b1;
    end
  end

  // ======================================================
  // Control, status and configuration registers
  // Hardware set beats a software clear in the same cycle
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {sm0_q, sm1_q, sm2_q, ren_q, tb8_q} <= 5'h00;
      ri_q <= 1'b0;
      ti_q <= 1'b0;
      rb8_q <= 1'b0;
      fe_q <= 1'b0;
      early_tx_flag_select_q <= 1'b0;
      evs_q <= 1'b0;
      dbl_q <= 1'b0;
      div_q <= `SPCM_DIV_RST;
      rx_buf_q <= 8'h00;
      irq_st_q <= `SPCM_IRQ_RST;
      irq_mask_q <= `SPCM_IRQ_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        sm1_q <= writedata[`SPCM_CTRL_MODE_LO];
        sm2_q <= writedata[`SPCM_CTRL_ADDR_FILT];
        ren_q <= writedata[`SPCM_CTRL_RX_EN];
        tb8_q <= writedata[`SPCM_CTRL_TX_NINTH];
        if (!evs_q)
          sm0_q <= writedata[`SPCM_CTRL_MODE_HI];
      end
      ri_q <= ri_ev | (ctrl_wr ? writedata[`SPCM_CTRL_RX_DONE] : ri_q);
      ti_q <= ti_ev | (ctrl_wr ? writedata[`SPCM_CTRL_TX_DONE] : ti_q);
      fe_q <= fe_ev | ((ctrl_wr && evs_q) ? writedata[`SPCM_CTRL_MODE_HI] : fe_q);
      if (rx_accept)
      begin
        rx_buf_q <= rx_sh_q;
        rb8_q <= nine_val;
      end
      else if (m0_ri_ev)
        rx_buf_q <= m0_data;
      if (stat_wr)
        early_tx_flag_select_q <= writedata[`SPCM_STAT_EARLY_TX];
      if (cfg_wr && byteenable[0])
      begin
        evs_q <= writedata[`SPCM_CFG_ERR_VIEW];
        dbl_q <= writedata[`SPCM_CFG_DBL_RATE];
      end
      if (cfg_wr && byteenable[1] && byteenable[2])
        div_q <= writedata[`SPCM_CFG_DIV_LSB+DIV_W-1:`SPCM_CFG_DIV_LSB];
      irq_st_q <= (irq_st_q & ~(ist_wr ? writedata[2:0] : 3'h0)) | {fe_ev, ti_ev, ri_ev};
      if (imk_wr)
        irq_mask_q <= writedata[2:0];
      irq_q <= |(irq_st_q & irq_mask_q);
    end
  end

  // ======================================================
  // Transmitter and mode-0 shift engine
  // Writes while a transfer runs are dropped, not queued
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_busy_q <= 1'b0;
      m0rx_q <= 1'b0;
      m0_smp_q <= 1'b0;
      tx_sh_q <= 11'h7ff;
      tx_bits_q <= 4'h0;
      tx_tick_q <= 4'h0;
    end
    else if (tx_start)
    begin
      tx_busy_q <= 1'b1;
      m0rx_q <= 1'b0;
      tx_tick_q <= 4'h0;
      case (mode)
        `SPCM_MODE_SHIFT:
        begin
          tx_sh_q <= {3'h7, writedata[7:0]};
          tx_bits_q <= `SPCM_BITS_M0;
        end
        `SPCM_MODE_8BIT:
        begin
          tx_sh_q <= {2'h3, writedata[7:0], 1'b0};
          tx_bits_q <= `SPCM_BITS_M1;
        end
        default:
        begin
          tx_sh_q <= {1'b1, tb8_q, writedata[7:0], 1'b0};
          tx_bits_q <= `SPCM_BITS_M23;
        end
      endcase
    end
    else if (m0rx_start)
    begin
      tx_busy_q <= 1'b1;
      m0rx_q <= 1'b1;
      tx_tick_q <= 4'h0;
      tx_bits_q <= `SPCM_BITS_M0;
    end
    else if (tx_busy_q && tick)
    begin
      tx_tick_q <= tx_tick_q + 4'h1;
      if (m0rx_q && (tx_tick_q == `SPCM_TICK_M0_SMP))
        m0_smp_q <= rxd_in;
      if (tx_tick_q == `SPCM_TICK_LAST)
      begin
        tx_bits_q <= tx_bits_q - 4'h1;
        if (m0rx_q)
          tx_sh_q <= {3'h7, m0_smp_q, tx_sh_q[7:1]};
        else
          tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        if (tx_last)
        begin
          tx_busy_q <= 1'b0;
          m0rx_q <= 1'b0;
        end
      end
    end
  end

  // ======================================================
  // Asynchronous receiver, modes 1 to 3
  // Start bit is rechecked at mid-bit to reject glitches
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_busy_q <= 1'b0;
      rx_prev_q <= 1'b1;
      nine_q <= 1'b0;
      rx_tick_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 8'h00;
    end
    else
    begin
      rx_prev_q <= rxd_in;
      if (!ren_q || mode0)
        rx_busy_q <= 1'b0;
      else if (!rx_busy_q)
      begin
        if (rx_prev_q && !rxd_in)
        begin
          rx_busy_q <= 1'b1;
          rx_tick_q <= 4'h0;
          rx_idx_q <= 4'h0;
        end
      end
      else if (tick)
      begin
        rx_tick_q <= rx_tick_q + 4'h1;
        if (rx_tick_q == `SPCM_TICK_LAST)
          rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_tick_q == `SPCM_TICK_MID)
        begin
          if (rx_idx_q == 4'h0)
          begin
            if (rxd_in)
              rx_busy_q <= 1'b0;
          end
          else if (rx_idx_q <= `SPCM_BITS_M0)
            rx_sh_q <= {rxd_in, rx_sh_q[7:1]};
          else if (rx_ninth)
            nine_q <= rxd_in;
          if (rx_stop)
            rx_busy_q <= 1'b0;
        end
      end
    end
  end

  // ======================================================
  // Pin drivers
  // Mode 0 clock is low for the first half of each bit
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txd_q <= 1'b1;
      rxd_out_q <= 1'b1;
      rxd_oe_q <= 1'b0;
    end
    else if (mode0)
    begin
      txd_q <= tx_busy_q ? tx_tick_q[3] : 1'b1;
      // Data pin idles high whenever it is released, also while receiving
      rxd_out_q <= (tx_busy_q && !m0rx_q) ? tx_sh_q[0] : 1'b1;
      rxd_oe_q <= tx_busy_q && !m0rx_q;
    end
    else
    begin
      txd_q <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      rxd_out_q <= 1'b1;
      rxd_oe_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== test/spcm_core_monitor.sv ====
// Pin and bus checker for the serial port core
`default_nettype none
module spcm_core_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata_q,
  input wire logic waitrequest_q,
  input wire logic irq_q,
  input wire logic rxd_in,
  input wire logic rxd_out_q,
  input wire logic rxd_oe_q,
  input wire logic txd_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;
  assign req = read | write;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // ======================================================
  // Register bus
  a_wait_answer: assert property (req && waitrequest_q |=> !waitrequest_q)
    else $error("waitrequest not lowered after one wait state");
  a_wait_single: assert property (!waitrequest_q |=> waitrequest_q)
    else $error("waitrequest low for more than one cycle");
  a_rdata_hold: assert property (waitrequest_q && $past(waitrequest_q) |-> $stable(readdata_q))
    else $error("read data changed outside an access");
  a_upper_zero: assert property (!waitrequest_q |-> readdata_q[31:24] == 8'h00)
    else $error("read data upper byte not zero");
  // ======================================================
  // Serial pins; bit time is at least sixteen clocks, each shift clock phase half of that in mode 0
  a_reset_idle: assert property ($rose(reset_n) |-> txd_q && rxd_out_q && !rxd_oe_q && !irq_q)
    else $error("pins not idle after reset");
  a_low_min: assert property ($fell(txd_q) |-> !txd_q [*8])
    else $error("transmit line low too briefly");
  a_high_min: assert property ($rose(txd_q) |-> txd_q [*8])
    else $error("transmit line high too briefly");
  a_out_idle: assert property (!rxd_oe_q |-> rxd_out_q)
    else $error("data pin output not idle while released");
  c_shift: cover property ($rose(rxd_oe_q));
  c_irq: cover property ($rose(irq_q));
  c_frame: cover property ($fell(txd_q) && !rxd_oe_q);
endmodule
bind spcm_core spcm_core_monitor mon (.*);
`default_nettype wire

// ==== test/spcm_peer.sv ====
// Remote serial peer: sends frames on the line and samples the transmit pin
`default_nettype none
module spcm_peer (
  input wire logic clock,
  input wire logic txd,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  // ======================================================
  // Frames, bit 0 first; line pulled up between frames
  task send(input logic [10:0] f, input int n, input int bc);
    for (int i = 0; i < n; i++)
    begin
      line <= f[i];
      repeat (bc) @(posedge clock);
    end
    line <= 1'b1;
  endtask
  task grab(input int n, input int bc, output logic [10:0] f);
    f = 11'h000;
    do @(posedge clock); while (txd !== 1'b0);
    repeat (bc / 2) @(posedge clock);
    for (int i = 0; i < n; i++)
    begin
      f[i] = txd;
      repeat (bc) @(posedge clock);
    end
  endtask
  // Mode 0 source: new bit after each falling shift clock
  task shift(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge txd);
      line <= v[i];
    end
    repeat (16) @(posedge clock);
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== test/spcm_core_bench.sv ====
// Self-checking bench of the serial port core
`include "spcm_regs.vh"
`default_nettype none
module spcm_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end
  logic clock, reset_n, read, write, rxd_in, peer_line, waitrequest_q, irq_q, rxd_out_q, rxd_oe_q, txd_q;
  logic [7:0] address, b;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata_q, d;
  logic [10:0] f;
  int miscompares, total_checks, cyc, t0;
  assign rxd_in = rxd_oe_q ? rxd_out_q : peer_line;
  spcm_core #(.DIV_W(16)) dut (.*);
  spcm_peer peer (.clock(clock), .txd(txd_q), .line(peer_line));
  // ======================================================
  // Bus tasks
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    address <= a;
    writedata <= v;
    write <= 1'b1;
    do @(posedge clock); while (waitrequest_q !== 1'b0);
    write <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest_q !== 1'b0);
    d = readdata_q;
    read <= 1'b0;
  endtask
  task poll(input int k);
    d = 32'h0;
    for (int i = 0; i < 400 && d[k] !== 1'b1; i++) rd(`SPCM_ADDR_CTRL);
  endtask
  task tx(input logic [7:0] c, input logic [7:0] v, input int n, input int bc, input logic [10:0] e);
    wr(`SPCM_ADDR_CTRL, {24'h0, c});
    wr(`SPCM_ADDR_DATA, {24'h0, v});
    peer.grab(n, bc, f);
    `CHK("frame", e, f)
    poll(1);
    `CHK("tx done", 1'b1, d[1])
  endtask
  // Flag looked at between the end of the last data bit and the end of stop
  task tx_flag(input logic s, input logic e);
    wr(`SPCM_ADDR_STAT, {25'h0, s, 6'h0});
    wr(`SPCM_ADDR_CTRL, 32'h40);
    wr(`SPCM_ADDR_DATA, 32'h81);
    repeat (150) @(posedge clock);
    rd(`SPCM_ADDR_CTRL);
    `CHK("tx done at stop start", e, d[1])
    repeat (20) @(posedge clock);
  endtask
  task rx(input logic [7:0] c, input logic [10:0] fr, input int n);
    wr(`SPCM_ADDR_CTRL, {24'h0, c});
    peer.send(fr, n, 16);
    repeat (4) @(posedge clock);
    rd(`SPCM_ADDR_CTRL);
  endtask
  // ======================================================
  // Scenarios
  task t_mode0;
    rd(`SPCM_ADDR_CTRL);
    `CHK("ctrl reset", 32'h0, d)
    rd(`SPCM_ADDR_CFG);
    `CHK("cfg reset", 32'h0f00, d)
    wr(`SPCM_ADDR_DATA, 32'h5a);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge txd_q);
      b[i] = rxd_out_q;
      if (i == 0) `CHK("m0 drive", 1'b1, rxd_oe_q)
      if (i == 1) t0 = cyc;
      if (i == 2) `CHK("m0 bit clocks", 16, cyc - t0)
    end
    `CHK("m0 data", 8'h5a, b)
    poll(1);
    `CHK("m0 tx done", 1'b1, d[1])
    wr(`SPCM_ADDR_CTRL, 32'h10);
    peer.shift(8'hc3);
    rd(`SPCM_ADDR_CTRL);
    `CHK("m0 rx done", 1'b1, d[0])
    rd(`SPCM_ADDR_DATA);
    `CHK("m0 rx byte", 32'hc3, d)
    wr(`SPCM_ADDR_CTRL, 32'h0);
  endtask
  task t_tx;
    wr(`SPCM_ADDR_CFG, 32'h0);
    tx(8'h40, 8'ha5, 10, 16, {1'b1, 8'ha5, 1'b0});
    tx_flag(1'b0, 1'b0);
    tx_flag(1'b1, 1'b1);
    rd(`SPCM_ADDR_STAT);
    `CHK("early flag select", 32'h40, d)
    wr(`SPCM_ADDR_STAT, 32'h0);
    tx(8'hc8, 8'h0f, 11, 16, {1'b1, 1'b1, 8'h0f, 1'b0});
    tx(8'h80, 8'h96, 11, 32, {1'b1, 1'b0, 8'h96, 1'b0});
    wr(`SPCM_ADDR_CFG, 32'h2);
    tx(8'h80, 8'h3c, 11, 16, {1'b1, 1'b0, 8'h3c, 1'b0});
  endtask
  task t_rx;
    rx(8'h40, {2'b11, 8'h11, 1'b0}, 10);
    `CHK("rx disabled", 1'b0, d[0])
    rx(8'h50, {2'b11, 8'h3c, 1'b0}, 10);
    `CHK("m1 rx done", 1'b1, d[0])
    `CHK("stop kept", 1'b1, d[2])
    rd(`SPCM_ADDR_DATA);
    `CHK("m1 byte", 32'h3c, d)
    rx(8'hf0, {2'b10, 8'h22, 1'b0}, 11);
    `CHK("filtered", 1'b0, d[0])
    fork
      peer.send({2'b11, 8'h33, 1'b0}, 11, 16);
      begin
        repeat (160) @(posedge clock);
        rd(`SPCM_ADDR_CTRL);
        `CHK("mid ninth", 1'b1, d[0])
        `CHK("ninth kept", 1'b1, d[2])
      end
    join
    rd(`SPCM_ADDR_DATA);
    `CHK("m3 byte", 32'h33, d)
  endtask
  task t_ferr;
    wr(`SPCM_ADDR_IRQ_MASK, 32'h4);
    rx(8'hd0, {2'b01, 8'h55, 1'b0}, 11);
    `CHK("fe irq", 1'b1, irq_q)
    rd(`SPCM_ADDR_STAT);
    `CHK("fe status", 32'h08, d)
    rd(`SPCM_ADDR_IRQ_STAT);
    `CHK("irq status", 32'h7, d)
    wr(`SPCM_ADDR_CFG, 32'h1);
    rd(`SPCM_ADDR_CTRL);
    `CHK("fe view", 1'b1, d[7])
    peer.send({2'b11, 8'h44, 1'b0}, 11, 16);
    rd(`SPCM_ADDR_CTRL);
    `CHK("fe sticky", 1'b1, d[7])
    wr(`SPCM_ADDR_IRQ_STAT, 32'h4);
    wr(`SPCM_ADDR_CTRL, 32'h50);
    rd(`SPCM_ADDR_CTRL);
    `CHK("fe cleared", 1'b0, d[7])
    `CHK("irq cleared", 1'b0, irq_q)
    wr(`SPCM_ADDR_CFG, 32'h0);
    rd(`SPCM_ADDR_CTRL);
    `CHK("mode view", 1'b1, d[7])
  endtask
  task end_sim;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ======================================================
  // Clock, reset, timeout and main sequence
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      end_sim;
    end
  end
  initial
  begin
    {reset_n, read, write, address, writedata} = '0;
    byteenable = 4'hf;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_mode0;
    t_tx;
    t_rx;
    t_ferr;
    end_sim;
  end
endmodule
`default_nettype wire
